/* rtl/uab_top.sv */
`timescale 1ns/10ps
`default_nettype none
module uab_top #(
   parameter int CLOCK_KHZ = uab_pkg::SYSTEM_CLOCK_KHZ
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // serial pins
   input wire logic receive_pin,
   output logic transmit_data_port,
   output logic [1:0] pin_oe_n,
   // results
   output uab_pkg::uab_baud_t baud_q,
   output logic baud_valid_q
);
   // =====================================================
   // register state
   logic [7:0] ctrl_q, peripheral_clock_gate_q, timer_clock_prescale_select_q, capture_channel_mode_high_q;
   logic [1:0] port_direction_reg_q;
   logic [7:0] rx_status_q, tx_status_q, rx_buf_q;
   logic rx_buf_full_q, tx_buffer_full_flag;
   logic [7:0] tx_hold_q;
   logic wr_ph_q, rd_ph_q;
   logic [7:0] addr_q;
   logic uart_en;
   logic start_edge_en_q;
   assign uart_en = ctrl_q[0];

   // =====================================================
   // pin synchroniser
   logic rx_meta_q, rx_sync_q, rx_prev_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end else begin
         rx_meta_q <= receive_pin;
         rx_sync_q <= rx_meta_q;
         rx_prev_q <= rx_sync_q;
      end
   end
   logic rx_fall, rx_rise;
   assign rx_fall = rx_prev_q & ~rx_sync_q;
   assign rx_rise = ~rx_prev_q & rx_sync_q;

   // =====================================================
   // timer clocks: divide by 2**field, counter stopped while gated off
   logic tau_on;
   logic [15:0] pre_cnt_q;
   logic [15:0] pre_cnt_d;
   logic tick_a, tick_b, tick_cap;
   assign tau_on = peripheral_clock_gate_q[0];
   assign pre_cnt_d = pre_cnt_q + 16'h0001;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) pre_cnt_q <= 16'h0000;
      else if (tau_on) pre_cnt_q <= pre_cnt_d;
   end
   function automatic logic tick_of(input logic [15:0] cnt, input logic [3:0] sel);
      logic [15:0] mask;
      mask = (16'h0001 << sel) - 16'h0001;
      return (cnt & mask) == mask;
   endfunction : tick_of
   assign tick_a = tau_on & tick_of(pre_cnt_q, timer_clock_prescale_select_q[3:0]);
   assign tick_b = tau_on & tick_of(pre_cnt_q, timer_clock_prescale_select_q[7:4]);
   // the clock choice itself is left to software; the bit steers both the count and the prescale field used for the divisor
   assign tick_cap = capture_channel_mode_high_q[uab_pkg::CAP_CLK_BIT] ? tick_b : tick_a;

   // =====================================================
   // measurement sequencer
   uab_pkg::uab_meas_t meas_q;
   logic [15:0] cap_cnt_q;
   logic [15:0] acc_lo_q;
   logic [7:0] acc_hi_q;
   logic [2:0] remain_q;
   logic [16:0] lo_sum;
   logic start_meas, send_check_q;
   assign lo_sum = {1'b0, acc_lo_q} + {1'b0, cap_cnt_q};
   assign start_meas = ctrl_q[1] & (meas_q == uab_pkg::ST_IDLE);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meas_q <= uab_pkg::ST_IDLE;
         start_edge_en_q <= 1'b0;
         remain_q <= 3'h0;
         acc_lo_q <= 16'h0000;
         acc_hi_q <= 8'h00;
         cap_cnt_q <= 16'h0000;
      end else begin
         if (tick_cap && meas_q == uab_pkg::ST_CAPTURE) cap_cnt_q <= cap_cnt_q + 16'h0001;
         case (meas_q)
            uab_pkg::ST_IDLE: begin
               if (start_meas) begin
                  meas_q <= uab_pkg::ST_ARMED;
                  start_edge_en_q <= 1'b1;
                  remain_q <= uab_pkg::CAPTURE_COUNT;
               end
            end
            uab_pkg::ST_ARMED: begin
               if (rx_fall && start_edge_en_q && tau_on) begin
                  meas_q <= uab_pkg::ST_CAPTURE;
                  start_edge_en_q <= 1'b0;
                  acc_lo_q <= 16'h0000;
                  acc_hi_q <= 8'h00;
                  cap_cnt_q <= 16'h0000;
               end
            end
            uab_pkg::ST_CAPTURE: begin
               if (rx_rise) begin
                  // the edge cycle itself belongs to the next interval, so none is lost
                  cap_cnt_q <= {15'h0000, tick_cap};
                  remain_q <= remain_q - 3'h1;
                  if (remain_q != uab_pkg::CAPTURE_COUNT) begin
                     acc_lo_q <= lo_sum[15:0];
                     acc_hi_q <= acc_hi_q + {7'h00, lo_sum[16]};
                  end
                  if (remain_q == 3'h1) meas_q <= uab_pkg::ST_COMPUTE;
               end
            end
            uab_pkg::ST_COMPUTE: meas_q <= uab_pkg::ST_DONE;
            uab_pkg::ST_DONE: begin
               if (!ctrl_q[1]) meas_q <= uab_pkg::ST_IDLE;
            end
            default: meas_q <= uab_pkg::ST_IDLE;
         endcase
      end
   end

   // =====================================================
   // baud computation: bit width in capture ticks, scaled to system clock
   // ticks are the capture clock, so the divisor is bit ticks times 2**sel
   logic [23:0] bit_ticks;
   logic [3:0] cap_sel;
   logic [39:0] divisor;
   logic [3:0] pre_pick;
   logic [39:0] scaled;
   logic [8:0] up;
   assign bit_ticks = {acc_hi_q, acc_lo_q} / 24'(uab_pkg::BITS_SPANNED);
   assign cap_sel = capture_channel_mode_high_q[uab_pkg::CAP_CLK_BIT]
      ? timer_clock_prescale_select_q[7:4] : timer_clock_prescale_select_q[3:0];
   assign divisor = {16'h0000, bit_ticks} << cap_sel;
   always_comb begin
      pre_pick = 4'h0;
      scaled = divisor;
      for (int i = uab_pkg::PRESCALE_MAX; i >= 0; i--) begin
         if ((divisor >> i) <= 40'(uab_pkg::DIV_LIMIT) && (divisor >> i) != 40'h0) begin
            pre_pick = 4'(i);
            scaled = divisor >> i;
         end
      end
      if (scaled > 40'(uab_pkg::DIV_LIMIT)) scaled = 40'(uab_pkg::DIV_LIMIT);
      up = 9'((scaled[8:0] + 9'h001) >> 1) - 9'h001;
   end
   // baud in bps for software readback: khz * 1000 / divisor
   logic [31:0] baud_bps_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         baud_q <= '0;
         baud_valid_q <= 1'b0;
         baud_bps_q <= 32'h0;
      end else if (meas_q == uab_pkg::ST_COMPUTE) begin
         baud_q.prescale <= pre_pick;
         baud_q.div_upper <= up[6:0];
         baud_valid_q <= 1'b1;
         baud_bps_q <= (divisor == 40'h0) ? 32'h0 : 32'((40'(CLOCK_KHZ) * 40'd1000) / divisor);
      end else if (start_meas) begin
         baud_valid_q <= 1'b0;
      end
   end

   // =====================================================
   // transmitter at the corrected rate
   logic [15:0] bit_div;
   logic [15:0] tx_cnt_q;
   logic [3:0] tx_bit_q;
   logic [9:0] tx_shift_q;
   logic tx_active_q;
   logic tx_start;
   assign bit_div = 16'(({24'h0, up[6:0], 1'b1} + 32'h1) << baud_q.prescale);
   assign tx_start = tx_buffer_full_flag & ~tx_active_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_active_q <= 1'b0;
         tx_cnt_q <= 16'h0000;
         tx_bit_q <= 4'h0;
         tx_shift_q <= 10'h3ff;
      end else if (tx_start) begin
         tx_active_q <= 1'b1;
         tx_shift_q <= {1'b1, tx_hold_q, 1'b0};
         tx_cnt_q <= 16'h0000;
         tx_bit_q <= 4'h0;
      end else if (tx_active_q) begin
         if (tx_cnt_q >= bit_div - 16'h0001) begin
            tx_cnt_q <= 16'h0000;
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == 4'h9) tx_active_q <= 1'b0;
         end else begin
            tx_cnt_q <= tx_cnt_q + 16'h0001;
         end
      end
   end
   logic tx_end;
   assign tx_end = tx_active_q && tx_bit_q == 4'h9 && tx_cnt_q >= bit_div - 16'h0001;
   assign transmit_data_port = tx_shift_q[0];
   assign pin_oe_n = port_direction_reg_q;

   // =====================================================
   // receiver: samples mid-bit once the rate is known
   logic rx_act_q;
   logic [15:0] rx_cnt_q;
   logic [3:0] rx_bit_q;
   logic [8:0] rx_sh_q;
   logic rx_end;
   logic rx_end_q;
   // one cycle after the stop sample, so the shifter already holds the stop bit
   assign rx_end = rx_end_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_act_q <= 1'b0;
         rx_cnt_q <= 16'h0000;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 9'h000;
         rx_end_q <= 1'b0;
      end else if (!rx_act_q) begin
         rx_end_q <= 1'b0;
         if (uart_en && baud_valid_q && rx_fall && meas_q != uab_pkg::ST_CAPTURE) begin
            rx_act_q <= 1'b1;
            rx_cnt_q <= {1'b0, bit_div[15:1]};
            rx_bit_q <= 4'h0;
         end
      end else if (rx_cnt_q == 16'h0000) begin
         rx_sh_q <= {rx_sync_q, rx_sh_q[8:1]};
         rx_cnt_q <= bit_div - 16'h0001;
         rx_bit_q <= rx_bit_q + 4'h1;
         rx_end_q <= rx_bit_q == 4'h9;
         if (rx_bit_q == 4'h9) rx_act_q <= 1'b0;
      end else begin
         rx_end_q <= 1'b0;
         rx_cnt_q <= rx_cnt_q - 16'h0001;
      end
   end

   // =====================================================
   // ahb-lite slave, zero wait states
   logic rd_rx;
   logic wr_tx_ok;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ph_q <= 1'b0;
         rd_ph_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (hready) begin
         wr_ph_q <= hsel & htrans[1] & hwrite;
         rd_ph_q <= hsel & htrans[1] & ~hwrite;
         addr_q <= haddr[7:0];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rd_rx = rd_ph_q && addr_q == uab_pkg::ADDR_RX_DATA;
   assign wr_tx_ok = wr_ph_q && addr_q == uab_pkg::ADDR_TX_DATA && !tx_buffer_full_flag;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= 8'h00;
         peripheral_clock_gate_q <= uab_pkg::CLK_GATE_RST;
         timer_clock_prescale_select_q <= uab_pkg::PRESCALE_RST;
         capture_channel_mode_high_q <= uab_pkg::CAP_MODE_RST;
         port_direction_reg_q <= uab_pkg::PORT_DIR_RST;
      end else if (wr_ph_q) begin
         case (addr_q)
            uab_pkg::ADDR_CTRL: ctrl_q <= hwdata[7:0];
            uab_pkg::ADDR_CLK_GATE: peripheral_clock_gate_q <= hwdata[7:0];
            uab_pkg::ADDR_PRESCALE: timer_clock_prescale_select_q <= hwdata[7:0];
            uab_pkg::ADDR_CAP_MODE: capture_channel_mode_high_q <= hwdata[7:0];
            uab_pkg::ADDR_PORT_DIR: port_direction_reg_q <= hwdata[1:0];
            default: ;
         endcase
      end
   end

   // transmit holding register; once the rate is set the check character is queued if the register is empty and no data write lands then
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_buffer_full_flag <= 1'b0;
         tx_hold_q <= 8'h00;
         tx_status_q <= uab_pkg::TX_DONE;
         send_check_q <= 1'b0;
      end else begin
         send_check_q <= meas_q == uab_pkg::ST_COMPUTE;
         if (tx_start) tx_buffer_full_flag <= 1'b0;
         if (wr_tx_ok) begin
            tx_buffer_full_flag <= 1'b1;
            tx_hold_q <= hwdata[7:0];
         end else if (send_check_q && !tx_buffer_full_flag) begin
            tx_buffer_full_flag <= 1'b1;
            tx_hold_q <= uab_pkg::TRAINING_CHAR;
         end
         // start wins over end when both land together
         if (wr_tx_ok || (send_check_q && !tx_buffer_full_flag)) tx_status_q[uab_pkg::TX_BUSY_BIT] <= 1'b1;
         else if (tx_end && !tx_buffer_full_flag) tx_status_q <= uab_pkg::TX_DONE;
      end
   end

   // receive buffer and status
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_status_q <= uab_pkg::RX_BUSY;
         rx_buf_q <= 8'h00;
         rx_buf_full_q <= 1'b0;
      end else begin
         if (rx_end) begin
            if (rx_buf_full_q && !rd_rx) rx_status_q <= uab_pkg::RX_OVERRUN;
            else if (!rx_sh_q[8]) rx_status_q <= uab_pkg::RX_FRAME_ERR;
            else begin
               rx_status_q <= uab_pkg::RX_OK;
               rx_buf_q <= rx_sh_q[7:0];
               rx_buf_full_q <= 1'b1;
            end
         end else if (rd_rx) begin
            rx_status_q <= uab_pkg::RX_BUSY;
            rx_buf_full_q <= 1'b0;
         end else if (wr_ph_q && addr_q == uab_pkg::ADDR_CTRL && hwdata[0]) begin
            rx_status_q <= uab_pkg::RX_BUSY;
         end
      end
   end

   // read mux
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) hrdata <= 32'h0;
      else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            uab_pkg::ADDR_CTRL: hrdata <= {24'h0, ctrl_q};
            uab_pkg::ADDR_CLK_GATE: hrdata <= {24'h0, peripheral_clock_gate_q};
            uab_pkg::ADDR_PRESCALE: hrdata <= {24'h0, timer_clock_prescale_select_q};
            uab_pkg::ADDR_CAP_MODE: hrdata <= {24'h0, capture_channel_mode_high_q};
            uab_pkg::ADDR_PORT_DIR: hrdata <= {30'h0, port_direction_reg_q};
            uab_pkg::ADDR_RX_DATA: hrdata <= {24'h0, rx_buf_q};
            uab_pkg::ADDR_STATUS: hrdata <= {9'h000, meas_q, tx_buffer_full_flag, baud_valid_q,
               rx_buf_full_q, tx_active_q, rx_status_q, tx_status_q};
            uab_pkg::ADDR_ACCUM: hrdata <= {8'h0, acc_hi_q, acc_lo_q};
            uab_pkg::ADDR_BAUD: hrdata <= {baud_bps_q[20:0], baud_q};
            default: hrdata <= 32'h0;
         endcase
      end
   end
endmodule : uab_top
`default_nettype wire

/* shared/uab_pkg.sv */
package uab_pkg;
   // =====================================================
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CLK_GATE = 8'h04;
   localparam logic [7:0] ADDR_PRESCALE = 8'h08;
   localparam logic [7:0] ADDR_CAP_MODE = 8'h0c;
   localparam logic [7:0] ADDR_PORT_DIR = 8'h10;
   localparam logic [7:0] ADDR_TX_DATA = 8'h14;
   localparam logic [7:0] ADDR_RX_DATA = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;
   localparam logic [7:0] ADDR_ACCUM = 8'h20;
   localparam logic [7:0] ADDR_BAUD = 8'h24;
   // =====================================================
   // reset values and codes
   localparam logic [7:0] CLK_GATE_RST = 8'h00;
   localparam logic [7:0] PRESCALE_RST = 8'h00;
   localparam logic [7:0] CAP_MODE_RST = 8'h01;
   localparam logic [1:0] PORT_DIR_RST = 2'h3;
   localparam logic [7:0] RX_OK = 8'h00;
   localparam logic [7:0] RX_OVERRUN = 8'h01;
   localparam logic [7:0] RX_FRAME_ERR = 8'h02;
   localparam logic [7:0] RX_BUSY = 8'h80;
   localparam logic [7:0] TX_DONE = 8'h00;
   localparam int TX_BUSY_BIT = 7;
   localparam int CAP_CLK_BIT = 7;
   localparam logic [2:0] CAPTURE_COUNT = 3'h5;
   localparam logic [7:0] TRAINING_CHAR = 8'h55;
   localparam int SYSTEM_CLOCK_KHZ = 20000;
   localparam int DIV_LIMIT = 256;
   localparam int BITS_SPANNED = 8;
   localparam int SYS_CLK_MHZ = 250;
   localparam int PRESCALE_W = 4;
   localparam int PRESCALE_MAX = 15;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ARMED = 3'b001,
      ST_CAPTURE = 3'b010,
      ST_COMPUTE = 3'b011,
      ST_DONE = 3'b100
   } uab_meas_t;

   typedef struct packed {
      logic [3:0] prescale;
      logic [6:0] div_upper;
   } uab_baud_t;
endpackage : uab_pkg

/* sim/uab_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module uab_checker #(
   parameter int CLOCK_KHZ = uab_pkg::SYSTEM_CLOCK_KHZ
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // ahb-lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // serial and results
   input wire logic receive_pin,
   input wire logic transmit_data_port,
   input wire logic [1:0] pin_oe_n,
   input wire uab_pkg::uab_baud_t baud_q,
   input wire logic baud_valid_q
);
   // =====================================================
   // data phase of a port direction write
   logic wr_dir_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_dir_q <= 1'b0;
      end else if (hready) begin
         wr_dir_q <= hsel && htrans[1] && hwrite && haddr[7:0] == uab_pkg::ADDR_PORT_DIR;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // =====================================================
   // properties
   a_ready_always: assert property (hreadyout)
      else $error("hreadyout dropped");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_dir_write: assert property (wr_dir_q |=> {30'h0, pin_oe_n} == ($past(hwdata) & 32'h3))
      else $error("pin direction not taken from write");
   a_dir_only: assert property ($changed(pin_oe_n) |-> $past(wr_dir_q))
      else $error("pin direction changed without write");
   a_reset_pins: assert property ($rose(arst_n) |-> pin_oe_n == 2'b11 && !baud_valid_q && transmit_data_port)
      else $error("pins not at reset state");
   a_baud_hold: assert property (baud_valid_q && $past(baud_valid_q) |-> $stable(baud_q))
      else $error("baud result moved while held");
   // the result follows the last rising edge closely; 12 cycles covers sync and compute
   a_valid_cause: assert property ($rose(baud_valid_q) |-> receive_pin && !$past(receive_pin, 12))
      else $error("result without a final rising edge");
   a_check_char: assert property ($rose(baud_valid_q) |-> ##[1:64] !transmit_data_port)
      else $error("check character not started");
   c_measured: cover property ($rose(baud_valid_q));
   c_dir_write: cover property (wr_dir_q);
   c_tx_start: cover property ($fell(transmit_data_port));
endmodule : uab_checker

bind uab_top uab_checker #(.CLOCK_KHZ(CLOCK_KHZ)) u_checker (.*);
`default_nettype wire

/* sim/uab_remote.sv */
`timescale 1ns/10ps
`default_nettype none
module uab_remote #(
   parameter int BIT_CYCLES = 600
) (
   // clock
   input wire logic clock,
   // line
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] got_byte;
   int got_cnt;
   initial begin
      line_out = 1'b1;
      got_byte = 8'h00;
      got_cnt = 0;
   end
   // =====================================================
   // sender: start, eight bits lsb first, stop; idle high as with a pull-up
   task automatic send(input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= frame[i];
         repeat (BIT_CYCLES) @(posedge clock);
      end
   endtask : send
   // =====================================================
   // receiver samples each of the eight data bits at its middle
   always begin
      @(negedge line_in);
      repeat (BIT_CYCLES / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge clock);
         got_byte[i] = line_in;
      end
      got_cnt++;
   end
endmodule : uab_remote
`default_nettype wire

/* sim/uart_autobaud_measurement_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_autobaud_measurement_bench;
   // bit time of the remote party in system clocks
   localparam int BIT = 600;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic rx_line;
   logic tx_line;
   logic [1:0] pin_oe_n;
   uab_pkg::uab_baud_t baud_q;
   logic baud_valid_q;
   logic [31:0] rd;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   assign hready = hreadyout;
   always #2 clock = ~clock;
   uab_top #(.CLOCK_KHZ(uab_pkg::SYSTEM_CLOCK_KHZ)) DUT (.clock(clock), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .receive_pin(rx_line),
      .transmit_data_port(tx_line), .pin_oe_n(pin_oe_n), .baud_q(baud_q), .baud_valid_q(baud_valid_q));
   uab_remote #(.BIT_CYCLES(BIT)) u_remote (.clock(clock), .line_in(tx_line), .line_out(rx_line));
   // =====================================================
   // helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask : bus
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(what, rd & m, e);
   endtask : rchk
   task automatic wait_got(input int n);
      for (int i = 0; i < 12 * BIT && u_remote.got_cnt != n; i++) @(posedge clock);
      chk("echo count", u_remote.got_cnt, n);
   endtask : wait_got
   // expected result: prescale so the divisor fits, then add 1, halve, subtract 1
   function automatic logic [10:0] baud_exp(input int w);
      int p;
      p = 0;
      while ((w >> p) > uab_pkg::DIV_LIMIT) p++;
      return {4'(p), 7'(((w >> p) + 1) / 2 - 1)};
   endfunction : baud_exp
   task automatic wrap_up;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // =====================================================
   // sequence
   initial begin
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rchk("status", uab_pkg::ADDR_STATUS, 32'hffff, {uab_pkg::RX_BUSY, uab_pkg::TX_DONE});
      rchk("clk gate", uab_pkg::ADDR_CLK_GATE, 32'hff, uab_pkg::CLK_GATE_RST);
      rchk("prescale", uab_pkg::ADDR_PRESCALE, 32'hff, uab_pkg::PRESCALE_RST);
      rchk("cap mode", uab_pkg::ADDR_CAP_MODE, 32'hff, uab_pkg::CAP_MODE_RST);
      rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
      chk("pin dir", pin_oe_n, uab_pkg::PORT_DIR_RST);
      bus(1'b1, uab_pkg::ADDR_PORT_DIR, 32'h2);
      @(posedge clock);
      chk("pin dir", pin_oe_n, 2'h2);
      bus(1'b1, uab_pkg::ADDR_CLK_GATE, 32'h1);
      // clock a undivided for the capture, clock b at divide by 128
      bus(1'b1, uab_pkg::ADDR_PRESCALE, 32'h70);
      rchk("prescale", uab_pkg::ADDR_PRESCALE, 32'hff, 32'h70);
      bus(1'b1, uab_pkg::ADDR_CAP_MODE, 32'h01);
      rchk("cap mode", uab_pkg::ADDR_CAP_MODE, 32'hff, 32'h01);
      bus(1'b1, uab_pkg::ADDR_CTRL, 32'h2);
      u_remote.send(uab_pkg::TRAINING_CHAR);
      for (int i = 0; i < 100 && baud_valid_q !== 1'b1; i++) @(posedge clock);
      chk("valid", baud_valid_q, 1'b1);
      rchk("accum", uab_pkg::ADDR_ACCUM, 32'hffffff, 8 * BIT);
      chk("baud", baud_q, baud_exp(8 * BIT / uab_pkg::BITS_SPANNED));
      rchk("tx busy", uab_pkg::ADDR_STATUS, 32'h80, 32'h80);
      wait_got(1);
      chk("echo", u_remote.got_byte, uab_pkg::TRAINING_CHAR);
      repeat (2 * BIT) @(posedge clock);
      rchk("tx done", uab_pkg::ADDR_STATUS, 32'hff, uab_pkg::TX_DONE);
      bus(1'b1, uab_pkg::ADDR_CTRL, 32'h3);
      rchk("rx busy", uab_pkg::ADDR_STATUS, 32'hff00, {uab_pkg::RX_BUSY, 8'h0});
      u_remote.send(8'ha3);
      repeat (8) @(posedge clock);
      rchk("rx ok", uab_pkg::ADDR_STATUS, 32'hff00, {uab_pkg::RX_OK, 8'h0});
      rchk("rx data", uab_pkg::ADDR_RX_DATA, 32'hff, 32'ha3);
      rchk("rx empty", uab_pkg::ADDR_STATUS, 32'hff00, {uab_pkg::RX_BUSY, 8'h0});
      // second character lands while the first is unread
      u_remote.send(8'h3c);
      u_remote.send(8'hc5);
      repeat (8) @(posedge clock);
      rchk("overrun", uab_pkg::ADDR_STATUS, 32'hff00, {uab_pkg::RX_OVERRUN, 8'h0});
      rchk("rx kept", uab_pkg::ADDR_RX_DATA, 32'hff, 32'h3c);
      rchk("rx empty", uab_pkg::ADDR_STATUS, 32'hff00, {uab_pkg::RX_BUSY, 8'h0});
      bus(1'b1, uab_pkg::ADDR_TX_DATA, 32'h96);
      rchk("tx busy", uab_pkg::ADDR_STATUS, 32'h80, 32'h80);
      wait_got(2);
      chk("tx char", u_remote.got_byte, 8'h96);
      repeat (2 * BIT) @(posedge clock);
      rchk("tx done", uab_pkg::ADDR_STATUS, 32'hff, uab_pkg::TX_DONE);
      wrap_up();
   end
endmodule : uart_autobaud_measurement_bench
`default_nettype wire
